// File: hw/bvp_pkg.sv
// Purpose: shared constants and carriers for the blit/vector parameter registers
// Assumes: 32-bit AHB-Lite register access, 25 MHz clock
// Notes:   printed offsets are not all multiples of four, so they are indices
package bvp_pkg;

  localparam logic [15:0] SIZE_IDX   = 16'h8104;
  localparam logic [15:0] SRCPOS_IDX = 16'h8108;
  localparam logic [15:0] CLR0_IDX   = 16'h810c;
  localparam logic [15:0] CLR1_IDX   = 16'h810e;
  localparam logic [15:0] START_IDX  = 16'h8120;
  localparam logic [15:0] STAT_IDX   = 16'h8121;

  localparam logic [31:0] SIZE_RST   = 32'h00000000;
  localparam logic [31:0] SRCPOS_RST = 32'h00000000;
  localparam logic [15:0] CLR0_RST   = 16'h0000;
  localparam logic [15:0] CLR1_RST   = 16'h0000;

  localparam int VLEN_W  = 14;
  localparam int HI_LSB  = 16;
  localparam int START_VEC_BIT = 0;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_BLT  = 3'b010,
    OP_VEC  = 3'b100
  } bvp_op_e;

  typedef struct packed {
    logic               isVector;
    logic        [15:0] bltWidth;
    logic        [15:0] bltHeight;
    logic        [13:0] vecLength;
    logic        [15:0] vecInitErr;
    logic signed [15:0] sourceCol;
    logic signed [15:0] sourceRow;
    logic signed [15:0] lineAxialStepErr;
    logic signed [15:0] lineMinorStepErr;
    logic               renderNone;
  } bvp_params_s;

  typedef struct packed {
    logic        sel;
    logic        write;
    logic [29:0] index;
  } bvp_req_s;

endpackage

// File: hw/bvp_ahb_slave.sv
// Purpose: AHB-Lite slave front end, zero wait states
// Assumes: single word transfers, response always OKAY
// Notes:   write data is taken in the data phase
module bvp_ahb_slave
  import bvp_pkg::*;
(
  input  wire logic        clock,     // system clock
  input  wire logic        rst_b,     // async reset, active low
  input  wire logic        hsel,      // slave select
  input  wire logic [31:0] haddr,     // byte address
  input  wire logic [1:0]  htrans,    // transfer type
  input  wire logic        hwrite,    // write when high
  input  wire logic        hready,    // bus ready
  output bvp_req_s         dataReq    // registered data-phase request
);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dataReq <= '0;
    end else if (hready) begin
      dataReq.sel   <= hsel && htrans[1];
      dataReq.write <= hwrite;
      dataReq.index <= haddr[31:2];
    end
  end

endmodule

// File: hw/bvp_field_view.sv
// Purpose: splits stored bits into BLT or vector meanings
// Assumes: operation kind latched at start
// Notes:   purely combinational
module bvp_field_view
  import bvp_pkg::*;
(
  input  wire logic        isVector,  // operation kind
  input  wire logic [31:0] sizeReg,   // size or vector init
  input  wire logic [31:0] srcPosReg, // source pos or error terms
  output bvp_params_s      params     // decoded view
);

  always_comb begin
    params = '0;
    params.isVector = isVector;
    if (isVector) begin
      params.vecLength        = sizeReg[HI_LSB +: VLEN_W];
      params.vecInitErr       = sizeReg[15:0];
      params.lineAxialStepErr = srcPosReg[31:16];
      params.lineMinorStepErr = srcPosReg[15:0];
      params.renderNone       = (sizeReg[HI_LSB +: VLEN_W] == 14'h0000);
    end else begin
      params.bltWidth  = sizeReg[31:16];
      params.bltHeight = sizeReg[15:0];
      params.sourceCol = srcPosReg[31:16];
      params.sourceRow = srcPosReg[15:0];
      params.renderNone = (sizeReg[15:0] == 16'h0000) || (sizeReg[31:16] == 16'h0000);
    end
  end

endmodule

// File: hw/bvp_regs.sv
// Purpose: parameter register bank for blit and vector operations
// Assumes: AHB-Lite master, whole-word single transfers
// Notes:   engine consumes params while opActive is high
// Operation
// - in a BLT the low half of the size register is the height and zero height draws nothing.
// - vector length is 14 bits, upper bits reserved, and zero length draws nothing.
// - source-position high half is source column for BLT and axial step error for vectors.
// - source-position low half is source row for BLT and minor step error for vectors.
// - expansion draws clear source bits with colour 0 and set bits with colour 1.
module bvp_regs
  import bvp_pkg::*;
(
  input  wire logic        clock,      // 25 MHz clock
  input  wire logic        rst_b,      // async reset, active low
  input  wire logic        hsel,       // slave select
  input  wire logic [31:0] haddr,      // byte address
  input  wire logic [1:0]  htrans,     // transfer type
  input  wire logic        hwrite,     // write strobe
  input  wire logic [2:0]  hsize,      // transfer size
  input  wire logic [31:0] hwdata,     // write data
  input  wire logic        hready,     // bus ready
  output logic      [31:0] hrdata,     // read data
  output logic             hreadyout,  // always ready
  output logic             hresp,      // always okay
  input  wire logic        opDone,     // engine finished
  input  wire logic        srcBit,     // mono source bit
  output bvp_params_s      params,     // latched operation params
  output logic             opActive,   // operation running
  output logic      [15:0] expandColor // expanded pixel colour
);

  bvp_req_s    dataReq;
  logic [31:0] sizeReg;
  logic [31:0] srcPosReg;
  logic [15:0] colorClear;
  logic [15:0] colorSet;
  bvp_op_e     opState;
  logic        startVec;
  bvp_params_s next_params;
  logic        wrEn;
  logic        rdEn;

  bvp_ahb_slave uSlave (
    .clock   (clock),
    .rst_b   (rst_b),
    .hsel    (hsel),
    .haddr   (haddr),
    .htrans  (htrans),
    .hwrite  (hwrite),
    .hready  (hready),
    .dataReq (dataReq)
  );

  bvp_field_view uView (
    .isVector  (startVec),
    .sizeReg   (sizeReg),
    .srcPosReg (srcPosReg),
    .params    (next_params)
  );

  assign wrEn     = dataReq.sel && dataReq.write;
  assign rdEn     = hsel && htrans[1] && !hwrite && hready;
  assign startVec = hwdata[START_VEC_BIT];

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sizeReg    <= SIZE_RST;
      srcPosReg  <= SRCPOS_RST;
      colorClear <= CLR0_RST;
      colorSet   <= CLR1_RST;
    end else if (wrEn) begin
      case (dataReq.index[15:0])
        SIZE_IDX:   sizeReg    <= hwdata;
        SRCPOS_IDX: srcPosReg  <= hwdata;
        CLR0_IDX:   colorClear <= hwdata[15:0];
        CLR1_IDX:   colorSet   <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // start latches the meaning of the stored bits
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      opState  <= OP_IDLE;
      params   <= '0;
      opActive <= 1'b0;
    end else begin
      case (opState)
        OP_IDLE: begin
          if (wrEn && dataReq.index[15:0] == START_IDX) begin
            params <= next_params;
            if (!next_params.renderNone) begin
              opState  <= startVec ? OP_VEC : OP_BLT;
              opActive <= 1'b1;
            end
          end
        end
        OP_BLT, OP_VEC: begin
          if (opDone) begin
            opState  <= OP_IDLE;
            opActive <= 1'b0;
          end
        end
        default: begin
          opState  <= OP_IDLE;
          opActive <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      expandColor <= 16'h0000;
    end else begin
      expandColor <= srcBit ? colorSet : colorClear;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (rdEn) begin
      case (haddr[17:2])
        SIZE_IDX:   hrdata <= sizeReg;
        SRCPOS_IDX: hrdata <= srcPosReg;
        CLR0_IDX:   hrdata <= {16'h0000, colorClear};
        CLR1_IDX:   hrdata <= {16'h0000, colorSet};
        STAT_IDX:   hrdata <= {29'h00000000, opState == OP_VEC, opState == OP_BLT, opActive};
        default:    hrdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

// File: tb/bvp_regs_checker.sv
// Purpose: port checks for the parameter registers
// Assumes: zero wait states
// Notes:   bound to bvp_regs below
module bvp_regs_checker
  import bvp_pkg::*;
(
  input wire logic        clock,    // clock
  input wire logic        rst_b,    // reset
  input wire logic        hsel,     // select
  input wire logic [31:0] haddr,    // address
  input wire logic [1:0]  htrans,   // transfer
  input wire logic        hwrite,   // write
  input wire logic [31:0] hwdata,   // data
  input wire logic        hready,   // ready
  input wire logic        opDone,   // done
  input wire logic        opActive, // running
  input wire bvp_params_s params    // fields
);
  timeunit 1ns;
  timeprecision 1ns;
  logic startPend;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b) startPend <= 1'b0;
    else startPend <= hsel && htrans[1] && hready && hwrite && haddr == {14'h0, START_IDX, 2'b00};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_kind_follow: assert property (startPend && !opActive |=>
    params.isVector == $past(hwdata[START_VEC_BIT])) else $error("kind not latched");
  a_blt_height: assert property ($rose(opActive) && !params.isVector |->
    params.bltHeight != 16'h0) else $error("zero height started");
  a_vec_length: assert property ($rose(opActive) && params.isVector |->
    params.vecLength != 14'h0) else $error("zero length started");
  a_none_idle: assert property (params.renderNone |-> !opActive)
    else $error("empty op running");
  a_params_hold: assert property (opActive && $past(opActive) |-> $stable(params))
    else $error("params moved");
  a_start_sets: assert property (startPend && !opActive |=>
    opActive == !params.renderNone) else $error("start wrong");
  a_active_hold: assert property (opActive && !opDone |=> opActive)
    else $error("op dropped");
  cover property ($rose(opActive) && params.isVector);
  cover property ($rose(opActive) && !params.isVector);
  cover property (startPend && params.renderNone);
endmodule
bind bvp_regs bvp_regs_checker chk (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .opDone(opDone),
  .opActive(opActive), .params(params));

// File: tb/bvp_regs_test.sv
// Purpose: random and corner tests of the parameter registers
// Assumes: zero wait states, byte address is four times the index
// Notes:   colours read back in the low half
module bvp_regs_test;
  import bvp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, b) begin numChecks++; if ((a) !== (b)) begin errTotal++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
  logic clock, rst_b, hsel, hwrite, opDone, srcBit, hreadyout, hresp, opActive;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r, sz, sp, c;
  logic [15:0] expandColor;
  bvp_params_s params;
  logic [15:0] regIdx [4] = '{SIZE_IDX, SRCPOS_IDX, CLR0_IDX, CLR1_IDX};
  int seed = 74832, errTotal = 0, numChecks = 0, cyc = 0, i, v;
  bvp_regs DUT (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .opDone(opDone), .srcBit(srcBit),
    .params(params), .opActive(opActive), .expandColor(expandColor));
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  function automatic logic none(int v, logic [31:0] s);
    return v ? s[29:16] == 0 : (s[31:16] == 0 || s[15:0] == 0);
  endfunction
  task automatic bus(input logic w, input logic [15:0] x, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {14'h0, x, 2'b00};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task end_sim;
    $display("checks=%0d mismatches=%0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      errTotal++;
      end_sim;
    end
  end
  initial begin
    {hsel, hwrite, opDone, srcBit, htrans, haddr, hwdata} <= '0;
    rst_b = 0;
    repeat (10) @(posedge clock);
    rst_b <= 1;
    for (i = 0; i < 4; i++) begin
      bus(0, regIdx[i], 0);
      `CHK(r, 32'h0)
      `CHK(hresp, 1'b0)
    end
    bus(1, 16'h0100, 32'hffffffff);
    bus(0, 16'h0100, 0);
    `CHK(r, 32'h0)
    for (i = 0; i < 6; i++) begin
      sz = $random(seed);
      sp = $random(seed);
      if (i == 1) sz[15:0] = 0;
      if (i == 2) sz[29:16] = 0;
      for (v = 0; v < 2; v++) begin
        bus(1, SIZE_IDX, sz);
        bus(1, SRCPOS_IDX, sp);
        bus(1, START_IDX, 32'(v));
        repeat (2) @(posedge clock);
        `CHK(params.isVector, v[0])
        `CHK(opActive, !none(v, sz))
        `CHK(params.renderNone, none(v, sz))
        if (v) begin
          `CHK(params.vecInitErr, sz[15:0])
          `CHK(params.vecLength, sz[29:16])
          `CHK(params.lineAxialStepErr, sp[31:16])
          `CHK(params.lineMinorStepErr, sp[15:0])
        end else begin
          `CHK(params.bltHeight, sz[15:0])
          `CHK(params.sourceCol, sp[31:16])
          `CHK(params.sourceRow, sp[15:0])
        end
        // a start while busy must be ignored
        if (!none(v, sz)) begin
          bus(0, STAT_IDX, 0);
          `CHK(r, {29'h0, v[0], ~v[0], 1'b1})
          bus(1, START_IDX, 32'(v ^ 1));
          @(posedge clock);
          `CHK(params.isVector, v[0])
        end
        opDone <= 1;
        @(posedge clock);
        opDone <= 0;
        @(posedge clock);
      end
    end
    for (i = 0; i < 4; i++) begin
      c = (i == 0) ? 32'h00005a5a : $random(seed);
      bus(1, CLR0_IDX, c);
      bus(1, CLR1_IDX, ~c);
      bus(0, CLR0_IDX, 0);
      `CHK(r, {16'h0, c[15:0]})
      for (v = 0; v < 2; v++) begin
        srcBit <= v[0];
        repeat (2) @(posedge clock);
        `CHK(expandColor, v ? ~c[15:0] : c[15:0])
      end
    end
    end_sim;
  end
endmodule
